// [hw/spd_dev.sv]
/*
 EEPROM slave: 256 bytes, lower-half write protection, reads with wrap.
 Assumes the bus clock is at most a sixteenth of clk_sys.
*/
`timescale 1ns/100ps
`include "spd_map.svh"
module spd_dev import spd_pkg::*; #(
   parameter int WR_CYC = `SPD_WR_CYC
) (
   input wire logic clk_sys,
   input wire logic nrst,
   spd_if.dev bus,
   output logic ready,
   output logic busy,
   output logic perm_prot,
   output logic rev_prot
);
   logic scl_f, sda_f;
   spd_glitch_filt #(.RST_VAL(1'b0)) u_scl (.clk_sys(clk_sys), .nrst(nrst),
      .pin(bus.scl), .flt(scl_f));
   spd_glitch_filt #(.RST_VAL(1'b1)) u_sda (.clk_sys(clk_sys), .nrst(nrst),
      .pin(bus.sda), .flt(sda_f));
   logic [2:0] apin_s1_r, apin_r;
   logic ov_s1_r, ov_r;

   logic [7:0] mem [0:255];
   logic [7:0] pg [0:15];
   spd_st_t st_r, st_nxt;
   spd_cmd_t cmd_r, cmd_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, addr_r, addr_nxt;
   logic ack_r, ack_nxt, mack_r, mack_nxt, oe_n_r, oe_n_nxt;
   logic wcyc_r, wcyc_nxt, pend_r, pend_nxt;
   logic busy_r, busy_nxt, ready_r, ready_nxt;
   logic perm_nv_r, perm_nv_nxt, rev_nv_r, rev_nv_nxt;
   logic perm_r, perm_nxt, rev_r, rev_nxt;
   logic [15:0] msk_r, msk_nxt;
   logic [16:0] tmr_r, tmr_nxt;
   logic [2:0] ldc_r, ldc_nxt;
   logic scl_d_r, sda_d_r;
   logic rise, fall, start, stop, pg_we, commit;
   logic mem_hit, is_rev, is_clr, is_perm, prot_ok, ack_c;

   assign bus.dev_sda_o = 1'b0;
   assign bus.dev_sda_oe_n = oe_n_r;
   assign ready = ready_r;
   assign busy = busy_r;
   assign perm_prot = perm_r;
   assign rev_prot = rev_r;

   assign rise = scl_f & ~scl_d_r;
   assign fall = ~scl_f & scl_d_r;
   assign start = scl_f & scl_d_r & sda_d_r & ~sda_f;
   assign stop = scl_f & scl_d_r & ~sda_d_r & sda_f;

   // decode of a received control byte
   always_comb
   begin
      mem_hit = (sh_r[7:4] == `SPD_FIX_MEM) && (sh_r[3:1] == apin_r);
      is_rev = ov_r && (sh_r[3:2] == `SPD_REV_PINS);
      is_clr = ov_r && (sh_r[3:2] == `SPD_CLR_PINS);
      is_perm = ~ov_r && (sh_r[3:1] == apin_r);
      // permanent state refuses every protection access, reversible its own
      prot_ok = (sh_r[7:4] == `SPD_FIX_PROT) && (is_rev | is_clr | is_perm)
         && ~perm_r && ~(rev_r && is_rev);
      ack_c = ~busy_r && (mem_hit || prot_ok);
   end

   always_comb
   begin
      st_nxt = st_r;
      cmd_nxt = cmd_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      tx_nxt = tx_r;
      addr_nxt = addr_r;
      ack_nxt = ack_r;
      mack_nxt = mack_r;
      oe_n_nxt = oe_n_r;
      wcyc_nxt = wcyc_r;
      pend_nxt = pend_r;
      busy_nxt = busy_r;
      ready_nxt = ready_r;
      perm_nv_nxt = perm_nv_r;
      rev_nv_nxt = rev_nv_r;
      perm_nxt = perm_r;
      rev_nxt = rev_r;
      msk_nxt = msk_r;
      tmr_nxt = tmr_r;
      ldc_nxt = ldc_r;
      pg_we = 1'b0;
      commit = 1'b0;
      if (busy_r)
      begin
         tmr_nxt = tmr_r + 17'h1;
         if (tmr_r == 17'(WR_CYC - 1))
         begin
            // flags and data change only when the cycle completes
            busy_nxt = 1'b0;
            commit = (cmd_r == CMD_MEM);
            msk_nxt = 16'h0;
            if (cmd_r == CMD_PERM)
            begin
               perm_nv_nxt = 1'b1;
               perm_nxt = 1'b1;
            end
            if (cmd_r == CMD_REV)
            begin
               rev_nv_nxt = 1'b1;
               rev_nxt = 1'b1;
            end
            if (cmd_r == CMD_CLR)
            begin
               rev_nv_nxt = 1'b0;
               rev_nxt = 1'b0;
            end
         end
      end
      if (st_r == ST_POR)
      begin
         oe_n_nxt = 1'b1;
         if (scl_f)
            st_nxt = ST_LOAD;
      end
      else if (st_r == ST_LOAD)
      begin
         ldc_nxt = ldc_r + 3'h1;
         if (ldc_r == `SPD_LOAD_CYC)
         begin
            perm_nxt = perm_nv_r;
            rev_nxt = rev_nv_r;
            ready_nxt = 1'b1;
            st_nxt = ST_IDLE;
         end
      end
      else if (start)
      begin
         // a repeated start drops any unfinished write
         st_nxt = ST_CTRL;
         cnt_nxt = 4'h0;
         ack_nxt = 1'b0;
         oe_n_nxt = 1'b1;
         pend_nxt = 1'b0;
         if (!busy_r)
            msk_nxt = 16'h0;
      end
      else if (stop)
      begin
         st_nxt = ST_IDLE;
         oe_n_nxt = 1'b1;
         pend_nxt = 1'b0;
         if (pend_r && !busy_r)
         begin
            busy_nxt = 1'b1;
            tmr_nxt = 17'h0;
         end
      end
      else if (st_r != ST_IDLE)
      begin
         if (rise)
         begin
            if (ack_r)
               mack_nxt = ~sda_f;
            else
            begin
               sh_nxt = {sh_r[6:0], sda_f};
               cnt_nxt = cnt_r + 4'h1;
            end
         end
         else if (fall && ack_r)
         begin
            ack_nxt = 1'b0;
            cnt_nxt = 4'h0;
            oe_n_nxt = 1'b1;
            if (st_r == ST_READ)
            begin
               if (mack_r)
               begin
                  tx_nxt = mem[addr_r];
                  addr_nxt = addr_r + 8'h1;
                  oe_n_nxt = mem[addr_r][7];
               end
               else
                  st_nxt = ST_IDLE;
            end
         end
         else if (fall && cnt_r == 4'h8)
         begin
            ack_nxt = 1'b1;
            oe_n_nxt = 1'b1;
            case (st_r)
               ST_CTRL:
               begin
                  if (!ack_c)
                     st_nxt = ST_IDLE;
                  else
                  begin
                     oe_n_nxt = 1'b0;
                     if (!mem_hit && sh_r[0])
                        st_nxt = ST_SKIP;
                     else if (sh_r[0])
                     begin
                        st_nxt = ST_READ;
                        mack_nxt = 1'b1;
                     end
                     else
                        st_nxt = ST_WADDR;
                     cmd_nxt = mem_hit ? CMD_MEM : is_perm ? CMD_PERM :
                        is_rev ? CMD_REV : CMD_CLR;
                     wcyc_nxt = is_perm || (is_rev && !rev_r)
                        || (is_clr && rev_r);
                  end
               end
               ST_WADDR:
               begin
                  oe_n_nxt = 1'b0;
                  st_nxt = ST_WDATA;
                  if (cmd_r == CMD_MEM)
                     addr_nxt = sh_r;
               end
               ST_WDATA:
               begin
                  if (cmd_r != CMD_MEM)
                  begin
                     oe_n_nxt = 1'b0;
                     pend_nxt = wcyc_r;
                     st_nxt = ST_SKIP;
                  end
                  else if (!addr_r[7] && (perm_r || rev_r))
                     st_nxt = ST_IDLE;
                  else
                  begin
                     oe_n_nxt = 1'b0;
                     pg_we = 1'b1;
                     msk_nxt = msk_r | (16'h1 << addr_r[3:0]);
                     // page write wraps inside the selected page
                     addr_nxt = {addr_r[7:4], addr_r[3:0] + 4'h1};
                     pend_nxt = 1'b1;
                  end
               end
               ST_READ:
                  oe_n_nxt = 1'b1;
               default:
                  oe_n_nxt = 1'b1;
            endcase
         end
         else if (fall && st_r == ST_READ && cnt_r != 4'h0)
            oe_n_nxt = tx_r[3'h7 - cnt_r[2:0]];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (pg_we)
         pg[addr_r[3:0]] <= sh_r;
      if (commit)
         for (int i = 0; i < 16; i++)
            if (msk_r[i])
               mem[{addr_r[7:4], 4'(i)}] <= pg[i];
   end

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         // a fresh die; the power-on reset seen on the bus keeps the flags
         st_r <= ST_POR;
         cmd_r <= CMD_MEM;
         cnt_r <= 4'h0;
         sh_r <= 8'h0;
         tx_r <= 8'h0;
         addr_r <= 8'h0;
         ack_r <= 1'b0;
         mack_r <= 1'b0;
         oe_n_r <= 1'b1;
         wcyc_r <= 1'b0;
         pend_r <= 1'b0;
         busy_r <= 1'b0;
         ready_r <= 1'b0;
         perm_nv_r <= 1'b0;
         rev_nv_r <= 1'b0;
         perm_r <= 1'b0;
         rev_r <= 1'b0;
         msk_r <= 16'h0;
         tmr_r <= 17'h0;
         ldc_r <= 3'h0;
         scl_d_r <= 1'b0;
         sda_d_r <= 1'b1;
         apin_s1_r <= 3'h0;
         apin_r <= 3'h0;
         ov_s1_r <= 1'b0;
         ov_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         cmd_r <= cmd_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         tx_r <= tx_nxt;
         addr_r <= addr_nxt;
         ack_r <= ack_nxt;
         mack_r <= mack_nxt;
         oe_n_r <= oe_n_nxt;
         wcyc_r <= wcyc_nxt;
         pend_r <= pend_nxt;
         busy_r <= busy_nxt;
         ready_r <= ready_nxt;
         perm_nv_r <= perm_nv_nxt;
         rev_nv_r <= rev_nv_nxt;
         perm_r <= perm_nxt;
         rev_r <= rev_nxt;
         msk_r <= msk_nxt;
         tmr_r <= tmr_nxt;
         ldc_r <= ldc_nxt;
         scl_d_r <= scl_f;
         sda_d_r <= sda_f;
         apin_s1_r <= bus.a_pin;
         apin_r <= apin_s1_r;
         ov_s1_r <= bus.ov;
         ov_r <= ov_s1_r;
      end
   end
endmodule

// [hw/spd_glitch_filt.sv]
/*
 Two-flop synchroniser followed by a pulse-width filter for one bus pin.
 Assumes clk_sys at the rate that SPD_GLITCH_CYC was derived from.
*/
`timescale 1ns/100ps
`include "spd_map.svh"
module spd_glitch_filt #(
   parameter logic RST_VAL = 1'b1
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic pin,
   output logic flt
);
   logic s1_r, s2_r, flt_r, flt_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   assign flt = flt_r;
   always_comb
   begin
      flt_nxt = flt_r;
      cnt_nxt = 2'h0;
      // a change must persist past the window before it is taken
      if (s2_r != flt_r)
      begin
         if (cnt_r >= 2'(`SPD_GLITCH_CYC))
            flt_nxt = s2_r;
         else
            cnt_nxt = cnt_r + 2'h1;
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         flt_r <= RST_VAL;
         cnt_r <= 2'h0;
      end
      else
      begin
         s1_r <= pin;
         s2_r <= s1_r;
         flt_r <= flt_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule

// [hw/spd_host.sv]
/*
 Bus master: writes, current and selective reads, protection commands.
 Assumes one request at a time; the bus clock is made here by a divider.
*/
`timescale 1ns/100ps
`include "spd_map.svh"
module spd_host import spd_pkg::*; (
   input wire logic clk_sys,
   input wire logic nrst,
   spd_if.host bus,
   input wire logic [2:0] strap,
   input wire logic req_valid,
   output logic req_ready,
   input wire spd_kind_t req_kind,
   input wire logic [6:0] req_dev,
   input wire logic req_ov,
   input wire logic [7:0] req_word,
   input wire logic [7:0] req_data,
   input wire logic [7:0] req_cnt,
   output logic rd_valid,
   output logic [7:0] rd_data,
   output logic done,
   output logic nack
);
   spd_hst_t st_r, st_nxt;
   spd_kind_t kind_r, kind_nxt;
   spd_op_t op;
   logic [7:0] txb;
   logic [6:0] dev_r, dev_nxt;
   logic [7:0] word_r, word_nxt, data_r, data_nxt, rem_r, rem_nxt, rsh_r, rsh_nxt;
   logic [7:0] rdd_r, rdd_nxt;
   logic [3:0] step_r, step_nxt, b_r, b_nxt;
   logic [1:0] q_r, q_nxt, tk_r, tk_nxt;
   logic scl_r, scl_nxt, oe_n_r, oe_n_nxt, rdy_r, rdy_nxt, rdv_r, rdv_nxt;
   logic done_r, done_nxt, nack_r, nack_nxt, ov_r, ov_nxt;
   logic [2:0] ap_r, ap_nxt;
   logic s1_r, s2_r;

   assign bus.scl = scl_r;
   assign bus.host_sda_o = 1'b0;
   assign bus.host_sda_oe_n = oe_n_r;
   assign bus.a_pin = ap_r;
   assign bus.ov = ov_r;
   assign req_ready = rdy_r;
   assign rd_valid = rdv_r;
   assign rd_data = rdd_r;
   assign done = done_r;
   assign nack = nack_r;

   // byte sequence of each transfer kind, indexed by step
   always_comb
   begin
      op = OP_STOP;
      txb = {dev_r, 1'b0};
      case (kind_r)
         K_WR:
            case (step_r)
               4'h0: op = OP_START;
               4'h1: op = OP_TX;
               4'h2: {op, txb} = {OP_TX, word_r};
               4'h3: {op, txb} = {OP_TX, data_r};
               default: op = OP_STOP;
            endcase
         K_CUR:
            case (step_r)
               4'h0: op = OP_START;
               4'h1: {op, txb} = {OP_TX, dev_r, 1'b1};
               4'h2: op = OP_RX;
               default: op = OP_STOP;
            endcase
         K_SEL:
            case (step_r)
               4'h0: op = OP_START;
               4'h1: op = OP_TX;
               4'h2: {op, txb} = {OP_TX, word_r};
               4'h3: op = OP_START;
               4'h4: {op, txb} = {OP_TX, dev_r, 1'b1};
               4'h5: op = OP_RX;
               default: op = OP_STOP;
            endcase
         default: op = OP_STOP;
      endcase
   end

   always_comb
   begin
      {st_nxt, kind_nxt, dev_nxt, word_nxt, data_nxt} = {st_r, kind_r, dev_r, word_r, data_r};
      {rem_nxt, rsh_nxt, rdd_nxt, step_nxt, b_nxt} = {rem_r, rsh_r, rdd_r, step_r, b_r};
      {q_nxt, tk_nxt, scl_nxt, oe_n_nxt} = {q_r, tk_r, scl_r, oe_n_r};
      {rdy_nxt, nack_nxt, ov_nxt, ap_nxt} = {rdy_r, nack_r, ov_r, ap_r};
      rdv_nxt = 1'b0;
      done_nxt = 1'b0;
      if (st_r == H_IDLE)
      begin
         ap_nxt = strap;
         if (req_valid && rdy_r)
         begin
            {kind_nxt, dev_nxt, word_nxt, data_nxt} = {req_kind, req_dev, req_word, req_data};
            rem_nxt = (req_cnt == 8'h0) ? 8'h1 : req_cnt;
            ov_nxt = req_ov;
            ap_nxt = req_ov ? {req_dev[2:1], 1'b0} : strap;
            {st_nxt, rdy_nxt, nack_nxt} = {H_RUN, 1'b0, 1'b0};
            {step_nxt, b_nxt, q_nxt, tk_nxt} = {4'h0, 4'h0, 2'h0, 2'h0};
            {scl_nxt, oe_n_nxt} = 2'b01;
         end
      end
      else
      begin
         tk_nxt = tk_r + 2'h1;
         if (tk_r == `SPD_QTR_CYC)
         begin
            tk_nxt = 2'h0;
            q_nxt = q_r + 2'h1;
            case (q_r)
               2'h0: scl_nxt = 1'b1;
               2'h1:
               begin
                  if (op == OP_START)
                     oe_n_nxt = 1'b0;
                  else if (op == OP_STOP)
                     oe_n_nxt = 1'b1;
                  else if (op == OP_TX && b_r == 4'h8)
                     nack_nxt = nack_r | s2_r;
                  else if (op == OP_RX && b_r != 4'h8)
                     rsh_nxt = {rsh_r[6:0], s2_r};
               end
               2'h2:
                  if (op != OP_STOP)
                     scl_nxt = 1'b0;
               default:
               begin
                  if (op == OP_STOP)
                     {st_nxt, rdy_nxt, done_nxt, ov_nxt} = {H_IDLE, 1'b1, 1'b1, 1'b0};
                  else if (op == OP_START)
                     step_nxt = step_r + 4'h1;
                  else if (b_r != 4'h8)
                     b_nxt = b_r + 4'h1;
                  else
                  begin
                     b_nxt = 4'h0;
                     if (op == OP_TX)
                        step_nxt = (nack_r | s2_r) ? 4'hF : step_r + 4'h1;
                     else
                     begin
                        rdv_nxt = 1'b1;
                        rdd_nxt = rsh_r;
                        rem_nxt = rem_r - 8'h1;
                        if (rem_r == 8'h1)
                           step_nxt = step_r + 4'h1;
                     end
                  end
                  // next slot opens with the clock low and the data set
                  oe_n_nxt = 1'b1;
                  if (op == OP_STOP)
                     oe_n_nxt = 1'b1;
                  else if (step_nxt != step_r || op == OP_RX || b_nxt != 4'h0)
                  begin
                     if (op == OP_TX && b_nxt != 4'h8 && step_nxt == step_r)
                        oe_n_nxt = txb[3'h7 - b_nxt[2:0]];
                     else if (op == OP_RX && b_nxt == 4'h8)
                        oe_n_nxt = (rem_r == 8'h1);
                  end
               end
            endcase
         end
      end
   end

   // first bit of a new byte and a stop's low level need the new step's op
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         {st_r, kind_r, dev_r, word_r, data_r} <= {H_IDLE, K_WR, 7'h0, 8'h0, 8'h0};
         {rem_r, rsh_r, rdd_r, step_r, b_r} <= {8'h0, 8'h0, 8'h0, 4'h0, 4'h0};
         {q_r, tk_r, scl_r, oe_n_r} <= {2'h0, 2'h0, 1'b1, 1'b1};
         {rdy_r, nack_r, ov_r, ap_r, rdv_r, done_r} <= {1'b0, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0};
         {s1_r, s2_r} <= 2'b11;
      end
      else
      begin
         {st_r, kind_r, dev_r, word_r, data_r} <= {st_nxt, kind_nxt, dev_nxt, word_nxt, data_nxt};
         {rem_r, rsh_r, rdd_r, step_r, b_r} <= {rem_nxt, rsh_nxt, rdd_nxt, step_nxt, b_nxt};
         {q_r, tk_r, scl_r} <= {q_nxt, tk_nxt, scl_nxt};
         // a new tx byte or stop takes its first level at the start of q0
         if (st_r == H_RUN && tk_r == 2'h0 && q_r == 2'h0 && b_r == 4'h0)
            oe_n_r <= (op == OP_TX) ? txb[7] : (op == OP_STOP) ? 1'b0 : oe_n_nxt;
         else
            oe_n_r <= oe_n_nxt;
         {rdy_r, nack_r, ov_r, ap_r, rdv_r, done_r} <= {1'b1 & (rdy_nxt | st_r == H_IDLE & st_nxt == H_IDLE), nack_nxt, ov_nxt, ap_nxt, rdv_nxt, done_nxt};
         {s1_r, s2_r} <= {bus.sda, s1_r};
      end
   end
endmodule

// [hw/spd_if.sv]
/*
 Two-wire bus between master and EEPROM slave, with address pins.
 Assumes open-drain data: each end pulls low while its enable is low.
*/
`timescale 1ns/100ps
interface spd_if;
   logic scl;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic sda;
   logic [2:0] a_pin;
   logic ov;
   // wired-and with pull-up
   assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
   modport dev (input scl, input sda, input a_pin, input ov,
      output dev_sda_o, output dev_sda_oe_n);
   modport host (output scl, input sda, output a_pin, output ov,
      output host_sda_o, output host_sda_oe_n);
endinterface

// [hw/spd_map.svh]
/*
 Constants of the serial presence detect EEPROM slave and of its bus master.
 Assumes inclusion by bare name from the package and the design modules.
*/
// Summary of operation
// - permanent protect locks lower half forever
// - no protection access acked once permanent
// - clear command removes reversible protection
// - protect commands use byte-write framing, contents ignored
// - master applies overvoltage and address levels
// - protected lower-half write: data byte NACKed
// - permanent: protect commands NACKed, no cycle
// - reversible: own command NACKed, others cycle
// - unprotected: protect cycles, clear acked only
// - status queries use write format, read bit
// - query acknowledge per state, later bytes NACKed
// - counter points past last byte, wraps
// - read address acked, then counter byte sent
// - master ends read with NACK, STOP
// - dummy write loads counter for selective read
// - sequential read continues while acked, wraps
// - bus inputs reject pulses under 50 ns
// - reset held while clock line low
// - power-up loads stored flags before operation
// - match fixed address plus pins or overvoltage
// - reversible: pins low; clear: pin1 high
// - no acknowledge during internal write cycle
`ifndef SPD_MAP_SVH
`define SPD_MAP_SVH
`define SPD_FIX_MEM 4'hA
`define SPD_FIX_PROT 4'h6
`define SPD_REV_PINS 2'h0
`define SPD_CLR_PINS 2'h1
`define SPD_CLK_NS 50
`define SPD_GLITCH_NS 50
`define SPD_GLITCH_CYC (((`SPD_GLITCH_NS) + (`SPD_CLK_NS) - 1) / (`SPD_CLK_NS))
`define SPD_WR_US 5000
`define SPD_WR_CYC (((`SPD_WR_US) * 1000) / (`SPD_CLK_NS))
`define SPD_LOAD_CYC 3'h4
`define SPD_QTR_CYC 2'h3
`endif

// [hw/spd_pkg.sv]
/*
 Types shared by the EEPROM slave and its bus master.
 Assumes spd_map.svh on the include path.
*/
`include "spd_map.svh"
package spd_pkg;
   typedef enum logic [2:0] {
      ST_POR = 3'h0, ST_LOAD = 3'h1, ST_IDLE = 3'h2, ST_CTRL = 3'h3,
      ST_WADDR = 3'h4, ST_WDATA = 3'h5, ST_READ = 3'h6, ST_SKIP = 3'h7
   } spd_st_t;
   typedef enum logic [1:0] {
      CMD_MEM = 2'h0, CMD_PERM = 2'h1, CMD_REV = 2'h2, CMD_CLR = 2'h3
   } spd_cmd_t;
   typedef enum logic [1:0] {
      K_WR = 2'h0, K_CUR = 2'h1, K_SEL = 2'h2
   } spd_kind_t;
   typedef enum logic [1:0] {
      OP_START = 2'h0, OP_TX = 2'h1, OP_RX = 2'h2, OP_STOP = 2'h3
   } spd_op_t;
   typedef enum logic {
      H_IDLE = 1'b0, H_RUN = 1'b1
   } spd_hst_t;
endpackage

// [verif/spd_bus_properties.sv]
/* Wire checks for the EEPROM slave and its bus master.
   Assumes plain bus signals of one spd_if and the system clock. */
`timescale 1ns/100ps
module spd_bus_properties (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_oe_n
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   sequence s_scl_high;
      scl [*8];
   endsequence
   sequence s_dev_low;
      !dev_sda_oe_n [*8];
   endsequence
   chk_dev_moves_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
      else $error("slave data moved with clock high");
   chk_dev_bit_held: assert property (!dev_sda_oe_n && $rose(scl) |-> s_dev_low)
      else $error("slave bit not held");
   chk_filter_delay: assert property ($fell(scl) |-> $stable(dev_sda_oe_n) [*2])
      else $error("slave reacted inside filter delay");
   chk_dev_releases: assert property ($fell(dev_sda_oe_n) |-> ##[1:300] dev_sda_oe_n)
      else $error("slave holds data low");
   chk_cond_by_host: assert property (scl && $past(scl) && $changed(sda) |-> dev_sda_oe_n)
      else $error("slave made start or stop");
   chk_scl_high_span: assert property ($rose(scl) |-> s_scl_high)
      else $error("clock high too short");
   chk_scl_low_span: assert property ($fell(scl) |-> !scl [*4])
      else $error("clock low too short");
   chk_start_clocked: assert property ($fell(sda) && scl |-> ##[1:16] !scl)
      else $error("no clock after start");
endmodule

// [verif/spd_eeprom_protect_read_tb.sv]
/* Bench joining the EEPROM slave and its bus master over one bus interface.
   Assumes spd_pkg, spd_if and the checker compiled before it. */
`timescale 1ns/100ps
module spd_eeprom_protect_read_tb import spd_pkg::*;;
   localparam logic [6:0] REV_ID = 7'h30;
   localparam logic [6:0] CLR_ID = 7'h32;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic req_valid = 1'b0;
   logic req_ov = 1'b0;
   logic [2:0] strap = 3'h5;
   logic [6:0] req_dev = 7'h00;
   logic [7:0] req_word = 8'h00;
   logic [7:0] req_data = 8'h00;
   logic [7:0] req_cnt = 8'h00;
   spd_kind_t req_kind = K_WR;
   logic req_ready, rd_valid, done, nack, ready, busy, perm_prot, rev_prot;
   logic [7:0] rd_data;
   logic [7:0] shadow [256];
   logic [7:0] rq [$];
   logic [7:0] wa [3] = '{8'hFF, 8'h00, 8'h01};
   logic [6:0] mem_id;
   logic [6:0] perm_id;
   int err_total = 0;
   int n_checks = 0;
   spd_if bus_if();
   assign mem_id = {4'hA, strap};
   assign perm_id = {4'h6, strap};
   // short write cycle so polling can still catch the slave busy
   spd_dev #(.WR_CYC(200)) i_spd_dev (.clk_sys(clk_sys), .nrst(nrst), .bus(bus_if.dev),
      .ready(ready), .busy(busy), .perm_prot(perm_prot), .rev_prot(rev_prot));
   spd_host i_spd_host (.clk_sys(clk_sys), .nrst(nrst), .bus(bus_if.host), .strap(strap),
      .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind), .req_dev(req_dev),
      .req_ov(req_ov), .req_word(req_word), .req_data(req_data), .req_cnt(req_cnt),
      .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack(nack));
   spd_bus_properties u_props (.clk_sys(clk_sys), .nrst(nrst), .scl(bus_if.scl),
      .sda(bus_if.sda), .dev_sda_oe_n(bus_if.dev_sda_oe_n));
   always #25 clk_sys = ~clk_sys;
   always @(negedge clk_sys)
      if (rd_valid === 1'b1)
         rq.push_back(rd_data);
   function automatic logic [7:0] exp_byte(input logic [7:0] a);
      return shadow[a];
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // entered 5 ns after a clock edge; every wait keeps that phase
   task automatic xfer(input spd_kind_t k, input logic [6:0] d, input logic o,
      input logic [7:0] w, input logic [7:0] c);
      req_kind = k;
      req_dev = d;
      req_ov = o;
      req_word = w;
      req_data = 8'($urandom);
      req_cnt = c;
      req_valid = 1'b1;
      while (req_ready !== 1'b1)
         #50;
      #50;
      req_valid = 1'b0;
      while (done !== 1'b1)
         #50;
   endtask
   // e holds nack, write cycle seen, permanent flag, reversible flag
   task automatic step(input spd_kind_t k, input logic [6:0] d, input logic o,
      input logic [7:0] w, input logic [7:0] c, input logic [3:0] e);
      logic b;
      xfer(k, d, o, w, c);
      #100;
      b = busy;
      while (busy === 1'b1)
         #50;
      chk({4'h0, nack, b, perm_prot, rev_prot}, {4'h0, e});
      if (b === 1'b1 && d == mem_id)
         shadow[w] = req_data;
   endtask
   initial
   begin
      void'($urandom(44130));
      strap = 3'($urandom);
      repeat (8)
         @(posedge clk_sys);
      #5;
      nrst = 1'b1;
      while (ready !== 1'b1)
         #50;
      foreach (wa[i])
         step(K_WR, mem_id, 1'b0, wa[i], 8'h00, 4'b0100);
      xfer(K_WR, mem_id, 1'b0, 8'h80, 8'h00);
      xfer(K_CUR, mem_id, 1'b0, 8'h00, 8'h00);
      chk({7'h00, nack}, 8'h01);
      rq.delete();
      step(K_SEL, mem_id, 1'b0, 8'hFF, 8'h02, 4'b0000);
      chk(8'(rq.size()), 8'h02);
      chk(rq[0], exp_byte(8'hFF));
      chk(rq[1], exp_byte(8'h00));
      rq.delete();
      step(K_CUR, mem_id, 1'b0, 8'h00, 8'h00, 4'b0000);
      chk(rq[0], exp_byte(8'h01));
      step(K_WR, CLR_ID, 1'b1, 8'($urandom), 8'h00, 4'b0000);
      step(K_CUR, REV_ID, 1'b1, 8'h00, 8'h00, 4'b0000);
      step(K_WR, REV_ID, 1'b1, 8'($urandom), 8'h00, 4'b0101);
      step(K_WR, REV_ID, 1'b1, 8'h00, 8'h00, 4'b1001);
      step(K_CUR, REV_ID, 1'b1, 8'h00, 8'h00, 4'b1001);
      step(K_CUR, CLR_ID, 1'b1, 8'h00, 8'h00, 4'b0001);
      step(K_WR, mem_id, 1'b0, 8'($urandom_range(127)), 8'h00, 4'b1001);
      step(K_WR, mem_id, 1'b0, 8'hC3, 8'h00, 4'b0101);
      step(K_WR, CLR_ID, 1'b1, 8'($urandom), 8'h00, 4'b0100);
      step(K_WR, mem_id, 1'b0, 8'($urandom_range(127)), 8'h00, 4'b0100);
      step(K_WR, REV_ID, 1'b1, 8'h00, 8'h00, 4'b0101);
      step(K_WR, perm_id, 1'b0, 8'h00, 8'h00, 4'b0111);
      step(K_WR, perm_id, 1'b0, 8'h00, 8'h00, 4'b1011);
      step(K_WR, CLR_ID, 1'b1, 8'h00, 8'h00, 4'b1011);
      step(K_CUR, perm_id, 1'b0, 8'h00, 8'h00, 4'b1011);
      step(K_WR, mem_id, 1'b0, 8'($urandom_range(127)), 8'h00, 4'b1011);
      report_and_stop();
   end
   initial
   begin
      #3000000;
      err_total++;
      report_and_stop();
   end
endmodule
